// ### core/eeprom_gate_host.sv
// Host-side sequencer driving a latched EEPROM through its write-gate glue.
// Assumes external glue holds the write strobe from our write until our next read.
// How it works
// [R01] Glue holds write strobe; device latches others
// [R02] Erase byte before writing new data
// [R03] Erase is a write of all ones
// [R04] Select valid before write strobe falls
// [R05] Glue flip-flop sets on selected write
// [R06] Device latches inputs on strobe fall
// [R07] Hold write pulse for full timed interval
// [R08] Any read of device ends the pulse
// [R09] Second read verifies after recovery time
// [R10] Device latches transparent during reads
// [R11] Read strobe frames output enable
// [R12] Chip select held for whole bus cycle
// [R13] Array select is OR of selects
// [R14] One gate flip-flop serves whole array
// [R15] Address strobe latches low address byte
// [R16] Reset leaves write strobe inactive
// [R17] Glue sets only with select present
`timescale 1ns/1ns
`include "eeprom_gate_defines.svh"
module eeprom_gate_host #(
  parameter int ADDR_W = `ADDR_W_DEF,
  parameter bit MUXED = 1'b1,
  parameter int TWP_CYC = `TWP_CYC
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire eeprom_gate_pkg::req_s REQ,
  output logic RSP_VALID,
  output logic [7:0] RSP_DATA,
  output logic RSP_ERR,
  output eeprom_gate_pkg::ctl_s CTL,
  output logic [ADDR_W-1:0] ADDR,
  input wire logic [7:0] DQ_IN,
  output logic [7:0] DQ_OUT,
  output logic DQ_OE
);

  localparam int TWRP_CYC = `TWRP_CYC;
  localparam int STROBE_CYC = `STROBE_CYC;

  initial begin
    if (ADDR_W < 1 || ADDR_W > 16) $error("eeprom_gate_host: ADDR_W out of range");
    if (TWP_CYC < 1 || TWP_CYC >= (1 << `TMR_W)) $error("eeprom_gate_host: bad TWP_CYC");
    if (STROBE_CYC < 1 || STROBE_CYC > 255) $error("eeprom_gate_host: bad STROBE_CYC");
  end

  eeprom_gate_pkg::phase_e phase, next_phase;
  eeprom_gate_pkg::step_e step, next_step;
  eeprom_gate_pkg::req_s req;
  logic [7:0] strb_cnt;
  logic [7:0] rd_data;
  logic tmr_load;
  logic tmr_done;
  logic [`TMR_W-1:0] tmr_count;
  logic finish;

  function automatic logic is_wr(input eeprom_gate_pkg::step_e s);
    is_wr = (s == eeprom_gate_pkg::ST_ERASE) || (s == eeprom_gate_pkg::ST_WRITE);
  endfunction

  function automatic logic is_term(input eeprom_gate_pkg::step_e s);
    is_term = (s == eeprom_gate_pkg::ST_TERM_E) || (s == eeprom_gate_pkg::ST_TERM_W);
  endfunction

  function automatic logic [7:0] expect_byte(input eeprom_gate_pkg::step_e s,
                                             input logic [7:0] d);
    expect_byte = (s == eeprom_gate_pkg::ST_VER_E || s == eeprom_gate_pkg::ST_ERASE) ?
                  `ERASE_BYTE : d;
  endfunction

  // Aborts on a failed erase verify rather than writing over dirty cells
  assign finish = (step == eeprom_gate_pkg::ST_READ) || (step == eeprom_gate_pkg::ST_VER_W) ||
                  (step == eeprom_gate_pkg::ST_VER_E && rd_data != `ERASE_BYTE);

  assign REQ_READY = (phase == eeprom_gate_pkg::PH_IDLE);
  assign tmr_load = (phase == eeprom_gate_pkg::PH_HOLD) && !finish &&
                    (is_wr(step) || is_term(step));
  assign tmr_count = is_wr(step) ? `TMR_W'(TWP_CYC) : `TMR_W'(TWRP_CYC); // R07 R09

  wait_timer #(.W(`TMR_W)) u_timer (
    .clk(CLK),
    .rst_n(RST_N),
    .load(tmr_load),
    .count(tmr_count),
    .done(tmr_done)
  );

  always_comb begin
    next_phase = phase;
    next_step = step;
    unique case (phase)
      eeprom_gate_pkg::PH_IDLE: begin
        if (REQ_VALID) begin
          next_phase = eeprom_gate_pkg::PH_ADDR;
          next_step = REQ.write ? eeprom_gate_pkg::ST_ERASE : eeprom_gate_pkg::ST_READ; // R02
        end
      end
      eeprom_gate_pkg::PH_ADDR: next_phase = eeprom_gate_pkg::PH_SETTLE;
      eeprom_gate_pkg::PH_SETTLE: next_phase = eeprom_gate_pkg::PH_STROBE; // R04
      eeprom_gate_pkg::PH_STROBE: begin
        if (strb_cnt == 8'h00) next_phase = eeprom_gate_pkg::PH_HOLD;
      end
      eeprom_gate_pkg::PH_HOLD: begin
        if (finish) begin
          next_phase = eeprom_gate_pkg::PH_IDLE;
        end else begin
          // Always one deselected cycle, so bus cycles never merge
          next_phase = eeprom_gate_pkg::PH_WAIT;
          // Write, terminating read, verify read, in that order
          unique case (step)
            eeprom_gate_pkg::ST_ERASE: next_step = eeprom_gate_pkg::ST_TERM_E;
            eeprom_gate_pkg::ST_TERM_E: next_step = eeprom_gate_pkg::ST_VER_E; // R09
            eeprom_gate_pkg::ST_VER_E: next_step = eeprom_gate_pkg::ST_WRITE; // R02
            eeprom_gate_pkg::ST_WRITE: next_step = eeprom_gate_pkg::ST_TERM_W; // R08
            default: next_step = eeprom_gate_pkg::ST_VER_W;
          endcase
        end
      end
      eeprom_gate_pkg::PH_WAIT: begin
        if (tmr_done) next_phase = eeprom_gate_pkg::PH_ADDR; // R07
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      phase <= eeprom_gate_pkg::PH_IDLE;
      step <= eeprom_gate_pkg::ST_READ;
    end else begin
      phase <= next_phase;
      step <= next_step;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      req <= '0;
    end else if (REQ_READY && REQ_VALID) begin
      req <= REQ;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      strb_cnt <= 8'h00;
    end else if (phase == eeprom_gate_pkg::PH_SETTLE) begin
      strb_cnt <= 8'(STROBE_CYC - 1);
    end else if (strb_cnt != 8'h00) begin
      strb_cnt <= strb_cnt - 8'h01;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rd_data <= 8'h00;
    end else if (phase == eeprom_gate_pkg::PH_STROBE && strb_cnt == 8'h00 && !is_wr(step)) begin
      rd_data <= DQ_IN;
    end
  end

  // Pins are registered from the next state so strobes never glitch
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      CTL <= 5'h1F; // R16
      ADDR <= '0;
      DQ_OUT <= 8'h00;
      DQ_OE <= 1'b0;
    end else begin
      CTL.chip_sel_n <= (next_phase == eeprom_gate_pkg::PH_IDLE) ||
                        (next_phase == eeprom_gate_pkg::PH_WAIT); // R12
      CTL.array_select_n <= (next_phase == eeprom_gate_pkg::PH_IDLE) ||
                            (next_phase == eeprom_gate_pkg::PH_WAIT); // R13 R17
      CTL.addr_strobe_n <= (next_phase != eeprom_gate_pkg::PH_ADDR); // R15
      CTL.mem_wr_n <= !(next_phase == eeprom_gate_pkg::PH_STROBE && is_wr(next_step)); // R05
      CTL.mem_rd_n <= !(next_phase == eeprom_gate_pkg::PH_STROBE && !is_wr(next_step)); // R11
      if (next_phase == eeprom_gate_pkg::PH_ADDR && phase != eeprom_gate_pkg::PH_ADDR) begin
        ADDR <= (phase == eeprom_gate_pkg::PH_IDLE) ? REQ.addr[ADDR_W-1:0] : req.addr[ADDR_W-1:0];
      end
      if (next_phase == eeprom_gate_pkg::PH_ADDR) begin
        DQ_OE <= MUXED;
        DQ_OUT <= (phase == eeprom_gate_pkg::PH_IDLE) ? REQ.addr[7:0] : req.addr[7:0]; // R15
      end else begin
        DQ_OE <= is_wr(next_step) && (next_phase == eeprom_gate_pkg::PH_SETTLE ||
                 next_phase == eeprom_gate_pkg::PH_STROBE || next_phase == eeprom_gate_pkg::PH_HOLD);
        DQ_OUT <= expect_byte(next_step, req.data); // R03
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      RSP_VALID <= 1'b0;
      RSP_DATA <= 8'h00;
      RSP_ERR <= 1'b0;
    end else begin
      RSP_VALID <= (phase == eeprom_gate_pkg::PH_HOLD) && finish;
      if (phase == eeprom_gate_pkg::PH_HOLD && finish) begin
        RSP_DATA <= rd_data;
        RSP_ERR <= (step != eeprom_gate_pkg::ST_READ) && (rd_data != expect_byte(step, req.data));
      end
    end
  end

  // Helper counters: cycles since the write strobe and the read strobe were last low
  logic [`TMR_W-1:0] since_wr, since_rd;
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      since_wr <= '0;
      since_rd <= '0;
    end else begin
      since_wr <= !CTL.mem_wr_n ? '0 : (&since_wr ? since_wr : since_wr + 1'b1);
      since_rd <= !CTL.mem_rd_n ? '0 : (&since_rd ? since_rd : since_rd + 1'b1);
    end
  end

  property p_erase_data;
    @(posedge CLK) disable iff (!RST_N)
    (!CTL.mem_wr_n && step == eeprom_gate_pkg::ST_ERASE) |-> DQ_OE && DQ_OUT == 8'hFF;
  endproperty
  a_erase_data: assert property (p_erase_data) else $error("erase data not all ones"); // R03

  property p_sel_first;
    @(posedge CLK) disable iff (!RST_N)
    $fell(CTL.mem_wr_n) |-> $past(!CTL.chip_sel_n, 1) && $past(!CTL.array_select_n, 1);
  endproperty
  a_sel_first: assert property (p_sel_first) else $error("write strobe before select"); // R04

  property p_wp_time;
    @(posedge CLK) disable iff (!RST_N)
    ($fell(CTL.mem_rd_n) && is_term(step)) |-> since_wr >= TWP_CYC;
  endproperty
  a_wp_time: assert property (p_wp_time) else $error("write pulse ended early"); // R07

  property p_erase_first;
    @(posedge CLK) disable iff (!RST_N)
    ($fell(CTL.mem_wr_n) && step == eeprom_gate_pkg::ST_WRITE) |-> rd_data == 8'hFF;
  endproperty
  a_erase_first: assert property (p_erase_first) else $error("write without erase"); // R02

  property p_recovery;
    @(posedge CLK) disable iff (!RST_N)
    ($fell(CTL.mem_rd_n) && (step == eeprom_gate_pkg::ST_VER_E ||
     step == eeprom_gate_pkg::ST_VER_W)) |-> since_rd >= TWRP_CYC;
  endproperty
  a_recovery: assert property (p_recovery) else $error("verify read too soon"); // R09

  property p_term_read;
    @(posedge CLK) disable iff (!RST_N)
    $rose(CTL.mem_wr_n) |-> CTL.mem_rd_n && !CTL.chip_sel_n ##1 CTL.chip_sel_n && is_term(step);
  endproperty
  a_term_read: assert property (p_term_read) else $error("write cycle did not close"); // R08

  property p_addr_strobe;
    @(posedge CLK) disable iff (!RST_N)
    $fell(CTL.addr_strobe_n) |-> CTL.mem_wr_n && CTL.mem_rd_n && !CTL.chip_sel_n
      ##1 CTL.addr_strobe_n [*2];
  endproperty
  a_addr_strobe: assert property (p_addr_strobe) else $error("bad address strobe"); // R15

  property p_reset_idle;
    @(posedge CLK) disable iff (!RST_N)
    $rose(RST_N) |-> CTL.mem_wr_n && CTL.mem_rd_n && CTL.chip_sel_n;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("strobe active after reset"); // R16

  property p_cs_cycle;
    @(posedge CLK) disable iff (!RST_N)
    $rose(CTL.mem_rd_n) |-> !CTL.chip_sel_n ##1 CTL.chip_sel_n;
  endproperty
  a_cs_cycle: assert property (p_cs_cycle) else $error("chip select dropped early"); // R12

  c_write: cover property (@(posedge CLK) RSP_VALID && !RSP_ERR && req.write);
  c_read: cover property (@(posedge CLK) RSP_VALID && !req.write);
  c_fail: cover property (@(posedge CLK) RSP_VALID && RSP_ERR);

endmodule

// ### core/eeprom_gate_defines.svh
// Constants for the latched-EEPROM write-gate host controller.
// Assumes a 20 MHz system clock; all times are converted to cycles here.
`ifndef EEPROM_GATE_DEFINES_SVH
`define EEPROM_GATE_DEFINES_SVH

`define CLK_KHZ 20000
`define TWP_MS 10
`define TWRP_US 100
`define TSTROBE_NS 250
`define TWP_CYC (`TWP_MS * `CLK_KHZ)
`define TWRP_CYC ((`TWRP_US * `CLK_KHZ + 999) / 1000)
`define STROBE_CYC ((`TSTROBE_NS * `CLK_KHZ + 999999) / 1000000)
`define ERASE_BYTE 8'hFF
`define ADDR_W_DEF 11
`define TMR_W 24

`endif

// ### core/eeprom_gate_pkg.sv
// Types shared by the write-gate host controller, its EEPROM model and its bench.
// Assumes the constants header is included by the users.
package eeprom_gate_pkg;

  typedef struct packed {
    logic write;
    logic [15:0] addr;
    logic [7:0] data;
  } req_s;

  typedef struct packed {
    logic chip_sel_n;
    logic array_select_n;
    logic mem_wr_n;
    logic mem_rd_n;
    logic addr_strobe_n;
  } ctl_s;

  typedef enum {PH_IDLE, PH_ADDR, PH_SETTLE, PH_STROBE, PH_HOLD, PH_WAIT} phase_e;

  typedef enum {ST_ERASE, ST_TERM_E, ST_VER_E, ST_WRITE, ST_TERM_W, ST_VER_W, ST_READ} step_e;

endpackage

// ### core/wait_timer.sv
// Loadable down-counter used for write-pulse and recovery timeouts.
// Assumes load is a one-cycle pulse from the sequencer.
`timescale 1ns/1ns
module wait_timer #(
  parameter int W = 24
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [W-1:0] count,
  output logic done
);

  logic [W-1:0] cnt;

  initial begin
    if (W < 2 || W > 31) $error("wait_timer: W out of range");
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (load) begin
      cnt <= count;
    end else if (cnt != '0) begin
      cnt <= cnt - 1'b1;
    end
  end

  assign done = (cnt == '0) && !load;

endmodule

// ### bench/latched_eeprom_model.sv
// Behavioural latched EEPROM plus its write-strobe glue flip-flop.
// Assumes host control pins change only just after a rising clock edge.
`timescale 1ns/1ns
module latched_eeprom_model #(
  parameter int TWP_CYC = 20
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire eeprom_gate_pkg::ctl_s ctl,
  input wire logic [10:0] addr,
  input wire logic [7:0] dq_from_host,
  input wire logic fail_erase,
  output logic [7:0] dq_to_host,
  output logic [7:0] viol
);
  logic [7:0] mem [0:2047];
  logic we_n = 1'b1;
  logic [7:0] low_addr, lat_data, last;
  logic [10:0] lat_addr;
  int pulse;
  logic rd_act;

  initial begin
    viol = 8'h00;
    last = 8'h00;
    for (int i = 0; i < 2048; i++) begin
      mem[i] = i[7:0] ^ 8'h3C;
    end
  end

  assign rd_act = !ctl.chip_sel_n && !ctl.mem_rd_n;
  // Released bus shows the inverse of the last byte, never a stale copy
  assign dq_to_host = rd_act ? mem[{addr[10:8], low_addr}] : ~last;

  always @(posedge clk) begin
    if (!ctl.addr_strobe_n) begin
      low_addr <= dq_from_host;
    end
    if (rd_act) begin
      last <= dq_to_host;
    end
    if ((!ctl.mem_wr_n || !ctl.mem_rd_n) && ctl.chip_sel_n) begin
      viol <= viol + 8'h01;
    end
    if (ctl.array_select_n !== ctl.chip_sel_n) begin
      viol <= viol + 8'h01;
    end
    if (!rst_n) begin
      we_n <= 1'b1;
      pulse <= 0;
    end else if (rd_act) begin
      we_n <= 1'b1;
      if (!we_n && pulse < TWP_CYC) begin
        viol <= viol + 8'h01;
      end else if (!we_n && lat_data == 8'hFF) begin
        mem[lat_addr] <= fail_erase ? 8'hFE : 8'hFF;
      end else if (!we_n) begin
        mem[lat_addr] <= mem[lat_addr] & lat_data; // Unerased bits stay low
      end
    end else if (!ctl.array_select_n && !ctl.mem_wr_n && we_n) begin
      we_n <= 1'b0;
      lat_addr <= {addr[10:8], low_addr};
      lat_data <= dq_from_host;
      pulse <= 0;
    end else if (!we_n) begin
      pulse <= pulse + 1;
    end
  end
endmodule

// ### bench/eeprom_gate_host_tb.sv
// Self-checking bench for the write-gate host against a latched EEPROM model.
// Assumes the model shares the host clock and reset.
`timescale 1ns/1ns
module eeprom_gate_host_tb;
  logic clk, rst_n, req_valid, req_ready, rsp_valid, rsp_err, dq_oe, fail_erase;
  eeprom_gate_pkg::req_s req;
  eeprom_gate_pkg::ctl_s ctl;
  logic [10:0] addr;
  logic [7:0] rsp_data, dq_in, dq_out, viol, d;
  logic e;
  int miscompares, total_checks;

  eeprom_gate_host #(.ADDR_W(11), .MUXED(1'b1), .TWP_CYC(20)) dut (
    .CLK(clk), .RST_N(rst_n), .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ(req),
    .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .RSP_ERR(rsp_err), .CTL(ctl),
    .ADDR(addr), .DQ_IN(dq_in), .DQ_OUT(dq_out), .DQ_OE(dq_oe));
  latched_eeprom_model #(.TWP_CYC(20)) mem_model (.clk(clk), .rst_n(rst_n), .ctl(ctl),
    .addr(addr), .dq_from_host(dq_out), .fail_erase(fail_erase), .dq_to_host(dq_in),
    .viol(viol));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // One request, held until taken, then a bounded wait for the answer
  task automatic request(input logic w, input logic [10:0] a, input logic [7:0] wd);
    int n;
    @(posedge clk);
    req_valid <= 1'b1;
    req <= {w, 5'h00, a, wd};
    do begin
      @(negedge clk);
    end while (req_ready !== 1'b1);
    @(posedge clk);
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 20000);
    chk({7'h00, rsp_valid}, 8'h01);
    d = rsp_data;
    e = rsp_err;
  endtask

  task automatic t_reset();
    chk({3'h0, ctl}, 8'h1F);
    chk({6'h00, dq_oe, req_ready}, 8'h01);
    chk({7'h00, mem_model.we_n}, 8'h01);
  endtask

  task automatic t_read_fresh();
    logic [10:0] al [3] = '{11'h7FF, 11'h000, 11'h1A5};
    foreach (al[i]) begin
      request(1'b0, al[i], 8'h00);
      chk(d, al[i][7:0] ^ 8'h3C);
    end
  endtask

  task automatic t_write(input logic [10:0] a, input logic [7:0] wd);
    request(1'b1, a, wd);
    chk({7'h00, e}, 8'h00);
    chk(d, wd);
    request(1'b0, a, 8'h00);
    chk(d, wd);
  endtask

  task automatic t_erase_fail();
    @(posedge clk);
    fail_erase <= 1'b1;
    request(1'b1, 11'h200, 8'h0F);
    chk({7'h00, e}, 8'h01);
    request(1'b0, 11'h200, 8'h00);
    chk(d, 8'hFE);
    @(posedge clk);
    fail_erase <= 1'b0;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    #(40000 * 50);
    miscompares++;
    $display("watchdog expired");
    end_sim();
  end

  initial begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    fail_erase = 1'b0;
    miscompares = 0;
    total_checks = 0;
    repeat (16) @(posedge clk);
    @(negedge clk);
    t_reset();
    @(posedge clk);
    rst_n <= 1'b1;
    t_read_fresh();
    t_write(11'h123, 8'hA5);
    // Clearing bits to 00 would show if the erase step were skipped
    t_write(11'h123, 8'h5A);
    request(1'b0, 11'h124, 8'h00);
    chk(d, 8'h24 ^ 8'h3C);
    t_erase_fail();
    chk(viol, 8'h00);
    end_sim();
  end
endmodule
